// >>> core/dab_pkg.sv
// Package for the converter register bank: register indices, field layouts, reset values.
// Assumes a 16-bit register word carried in the low half of a 32-bit AXI4-Lite data bus.
package dab_pkg;
  localparam int unsigned REG_W         = 16;
  localparam int unsigned IDX_W         = 6;
  // Printed offsets are register indices; byte address is four times the index.
  localparam logic [5:0] IDX_NO_OPERATION    = 6'h00;
  localparam logic [5:0] IDX_CONVERTER_CODE  = 6'h01;
  localparam logic [5:0] IDX_SPECIAL_CONFIG  = 6'h0B;
  localparam logic [5:0] IDX_UART_BREAK_MODE = 6'h16;
  localparam logic [5:0] IDX_GENERAL_STATUS  = 6'h21;
  localparam logic [5:0] IDX_ADC_FAULT_FLAGS = 6'h23;
  localparam logic [5:0] IDX_ADC_IN0         = 6'h24;
  localparam logic [5:0] IDX_ADC_IN1         = 6'h25;
  localparam logic [5:0] IDX_ADC_TEMP        = 6'h26;
  localparam logic [5:0] IDX_ADC_SELFDIAG    = 6'h27;
  localparam logic [5:0] IDX_ADC_OFFSET      = 6'h28;
  localparam logic [5:0] IDX_CONV_READBACK   = 6'h2C;
  localparam logic [5:0] IDX_ADC_OUTPUT      = 6'h2D;
  localparam logic [5:0] IDX_ADC_BYPASS      = 6'h2E;
  localparam logic [5:0] IDX_FORCED_FAULT    = 6'h2F;
  // Field masks: reserved bits are zero.
  localparam logic [15:0] MASK_ADC_DATA      = 16'h0FFF;
  localparam logic [15:0] MASK_GENERAL_STATUS    = 16'h91FF;
  localparam logic [15:0] MASK_ADC_FLAGS     = 16'h01FE;
  localparam logic [15:0] MASK_ADC_BYPASS    = 16'hEFFF;
  localparam logic [15:0] MASK_FORCED_FAULT  = 16'hF3FF;
  localparam logic [15:0] MASK_SPECIAL_CONFIG   = 16'h001F;
  localparam logic [15:0] MASK_BREAK_MODE    = 16'h0001;
  localparam logic [15:0] RST_CONVERTER_CODE = 16'h0000;
  localparam logic [15:0] RST_ADC_BYPASS     = 16'h0000;
  localparam logic [15:0] RST_FORCED_FAULT   = 16'h0000;
  localparam logic [15:0] RST_SPECIAL_CONFIG    = 16'h0000;
  localparam logic [15:0] RST_BREAK_MODE     = 16'h0000;
  localparam logic [15:0] ZERO_WORD          = 16'h0000;
  localparam logic [1:0]  RESP_OKAY          = 2'b00;
  localparam logic [1:0]  RESP_SLVERR        = 2'b10;
  typedef enum logic [1:0] {
    DAB_IDLE = 2'b00,
    DAB_RESP = 2'b01
  } dab_chan_e;
endpackage

// >>> core/dab_special_config.sv
// Power-on-only configuration word, kept apart from the functional reset domain.
// Assumes por_n is a synchronous active-low power-on reset on the same clock.
`timescale 1ns/10ps
module dab_special_config (
  input  wire logic        clock,
  input  wire logic        por_n,
  input  wire logic        wr_en,
  input  wire logic [15:0] wr_data,
  output logic      [15:0] cfg_q
);
  // Only the power-on reset clears this word; pin and software reset never reach it.
  always_ff @(posedge clock) begin
    if (!por_n) begin
      cfg_q <= dab_pkg::RST_SPECIAL_CONFIG;
    end else if (wr_en) begin
      cfg_q <= wr_data & dab_pkg::MASK_SPECIAL_CONFIG;
    end
  end
endmodule

// >>> core/dab_register_bank.sv
// Register bank of the converter: AXI4-Lite slave, code, bypass and fault-injection registers.
// Assumes status and result inputs are synchronous to clock; break-mode accesses come
// from the serial frame logic on the same clock over the break_* port.
`timescale 1ns/10ps
module dab_register_bank (
  input  wire logic        clock,
  input  wire logic        rst_n,
  input  wire logic        por_n,
  input  wire logic        software_reset_command,
  // AXI4-Lite slave.
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // Break-mode command port.
  input  wire logic        break_cmd_valid,
  input  wire logic        break_cmd_write,
  input  wire logic [5:0]  break_cmd_index,
  input  wire logic [15:0] break_cmd_wdata,
  output logic [15:0]      break_rdata_q,
  // Device state seen by software.
  input  wire logic [15:0] general_status,
  input  wire logic [15:0] adc_fault_flags,
  input  wire logic [11:0] adc_input0_result,
  input  wire logic [11:0] adc_input1_result,
  input  wire logic [11:0] adc_temperature_result,
  input  wire logic [11:0] adc_selfdiag_result,
  input  wire logic [11:0] adc_offset_result,
  input  wire logic [15:0] converter_output_readback,
  input  wire logic [11:0] adc_output_result,
  // Control outputs.
  output logic [15:0]      voltage_output_q,
  output logic [15:0]      adc_bypass_q,
  output logic [15:0]      forced_fault_q,
  output logic [15:0]      special_config_q,
  output logic             uart_break_mode_q
);
  logic        func_rst_n;
  logic        aw_held_q;
  logic        w_held_q;
  logic [5:0]  aw_idx_q;
  logic [15:0] w_data_q;
  logic [1:0]  w_strb_q;
  logic        wr_fire;
  logic        wr_hit;
  logic        rd_hit;
  logic [15:0] rd_word;
  logic [5:0]  ar_idx;
  logic [15:0] wr_lane_mask;
  logic [15:0] special_config_w;
  logic        special_wr;
  logic [15:0] break_mode_q;
  logic [11:0] adc_raw [6];
  logic [15:0] adc_word [6];
  dab_pkg::dab_chan_e wr_state_q;
  dab_pkg::dab_chan_e rd_state_q;

  // Pin reset and software reset share one functional reset; power-on reset covers both.
  assign func_rst_n = rst_n & por_n & ~software_reset_command;

  // Address and data may arrive in either order; each is held until both are present.
  assign wr_fire = aw_held_q & w_held_q & (wr_state_q == dab_pkg::DAB_IDLE);
  assign wr_lane_mask = {{8{w_strb_q[1]}}, {8{w_strb_q[0]}}};

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      aw_held_q <= 1'b0;
      aw_idx_q  <= 6'h00;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_held_q <= 1'b1;
      aw_idx_q  <= s_axi_awaddr[7:2];
    end else if (wr_fire) begin
      aw_held_q <= 1'b0;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      w_held_q <= 1'b0;
      w_data_q <= 16'h0000;
      w_strb_q <= 2'b00;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_held_q <= 1'b1;
      w_data_q <= s_axi_wdata[15:0];
      w_strb_q <= s_axi_wstrb[1:0];
    end else if (wr_fire) begin
      w_held_q <= 1'b0;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
    end else begin
      s_axi_awready <= ~aw_held_q & ~(s_axi_awvalid & s_axi_awready) & ~s_axi_bvalid;
      s_axi_wready  <= ~w_held_q & ~(s_axi_wvalid & s_axi_wready) & ~s_axi_bvalid;
    end
  end

  // Index decode of writable registers; the break-mode index is not decoded here.
  always_comb begin
    case (aw_idx_q)
      dab_pkg::IDX_NO_OPERATION,
      dab_pkg::IDX_CONVERTER_CODE,
      dab_pkg::IDX_SPECIAL_CONFIG,
      dab_pkg::IDX_ADC_BYPASS,
      dab_pkg::IDX_FORCED_FAULT: wr_hit = 1'b1;
      default:                   wr_hit = 1'b0;
    endcase
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= dab_pkg::RESP_OKAY;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= wr_hit ? dab_pkg::RESP_OKAY : dab_pkg::RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Write channel state gates the next write; a new one waits until bready takes the answer.
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      wr_state_q <= dab_pkg::DAB_IDLE;
    end else begin
      case (wr_state_q)
        dab_pkg::DAB_IDLE: begin
          if (wr_fire) begin
            wr_state_q <= dab_pkg::DAB_RESP;
          end
        end
        dab_pkg::DAB_RESP: begin
          if (s_axi_bready) begin
            wr_state_q <= dab_pkg::DAB_IDLE;
          end
        end
        default: begin
          wr_state_q <= dab_pkg::DAB_IDLE;
        end
      endcase
    end
  end

  // A byte lane with a clear strobe keeps the old contents of that byte.
  function automatic logic [15:0] merge(input logic [15:0] old_v, input logic [15:0] mask);
    merge = ((old_v & ~wr_lane_mask) | (w_data_q & wr_lane_mask)) & mask;
  endfunction

  always_ff @(posedge clock) begin
    if (!func_rst_n) begin
      voltage_output_q <= dab_pkg::RST_CONVERTER_CODE;
    end else if (wr_fire && aw_idx_q == dab_pkg::IDX_CONVERTER_CODE) begin
      voltage_output_q <= merge(voltage_output_q, 16'hFFFF);
    end
  end

  always_ff @(posedge clock) begin
    if (!func_rst_n) begin
      adc_bypass_q <= dab_pkg::RST_ADC_BYPASS;
    end else if (wr_fire && aw_idx_q == dab_pkg::IDX_ADC_BYPASS) begin
      adc_bypass_q <= merge(adc_bypass_q, dab_pkg::MASK_ADC_BYPASS);
    end
  end

  always_ff @(posedge clock) begin
    if (!func_rst_n) begin
      forced_fault_q <= dab_pkg::RST_FORCED_FAULT;
    end else if (wr_fire && aw_idx_q == dab_pkg::IDX_FORCED_FAULT) begin
      forced_fault_q <= merge(forced_fault_q, dab_pkg::MASK_FORCED_FAULT);
    end
  end

  // Writes to the no-operation index are accepted with OKAY and touch no register.

  assign special_wr    = wr_fire && aw_idx_q == dab_pkg::IDX_SPECIAL_CONFIG;
  assign special_config_w = merge(special_config_q, dab_pkg::MASK_SPECIAL_CONFIG);

  dab_special_config u_special_config (
    .clock   (clock),
    .por_n   (por_n),
    .wr_en   (special_wr),
    .wr_data (special_config_w),
    .cfg_q   (special_config_q)
  );

  // Break-mode register lives only behind the break command port.
  always_ff @(posedge clock) begin
    if (!func_rst_n) begin
      break_mode_q <= dab_pkg::RST_BREAK_MODE;
    end else if (break_cmd_valid && break_cmd_write &&
                 break_cmd_index == dab_pkg::IDX_UART_BREAK_MODE) begin
      break_mode_q <= break_cmd_wdata & dab_pkg::MASK_BREAK_MODE;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      uart_break_mode_q <= 1'b0;
      break_rdata_q     <= 16'h0000;
    end else begin
      uart_break_mode_q <= break_mode_q[0];
      if (break_cmd_valid && !break_cmd_write) begin
        break_rdata_q <= (break_cmd_index == dab_pkg::IDX_UART_BREAK_MODE) ?
                         break_mode_q : dab_pkg::ZERO_WORD;
      end
    end
  end

  // Every ADC result word carries 12 data bits under a reserved upper nibble that reads zero.
  assign adc_raw[0] = adc_input0_result;
  assign adc_raw[1] = adc_input1_result;
  assign adc_raw[2] = adc_temperature_result;
  assign adc_raw[3] = adc_selfdiag_result;
  assign adc_raw[4] = adc_offset_result;
  assign adc_raw[5] = adc_output_result;
  for (genvar k = 0; k < 6; k++) begin : g_adc_word
    assign adc_word[k] = {4'h0, adc_raw[k]};
  end

  // Read decode.
  assign ar_idx = s_axi_araddr[7:2];

  always_comb begin
    rd_hit  = 1'b1;
    rd_word = dab_pkg::ZERO_WORD;
    case (ar_idx)
      dab_pkg::IDX_NO_OPERATION:    rd_word = dab_pkg::ZERO_WORD;
      dab_pkg::IDX_CONVERTER_CODE:  rd_word = voltage_output_q;
      dab_pkg::IDX_SPECIAL_CONFIG:  rd_word = special_config_q;
      dab_pkg::IDX_GENERAL_STATUS:  rd_word = general_status & dab_pkg::MASK_GENERAL_STATUS;
      dab_pkg::IDX_ADC_FAULT_FLAGS: rd_word = adc_fault_flags & dab_pkg::MASK_ADC_FLAGS;
      dab_pkg::IDX_ADC_IN0:         rd_word = adc_word[0];
      dab_pkg::IDX_ADC_IN1:         rd_word = adc_word[1];
      dab_pkg::IDX_ADC_TEMP:        rd_word = adc_word[2];
      dab_pkg::IDX_ADC_SELFDIAG:    rd_word = adc_word[3];
      dab_pkg::IDX_ADC_OFFSET:      rd_word = adc_word[4];
      dab_pkg::IDX_CONV_READBACK:   rd_word = converter_output_readback;
      dab_pkg::IDX_ADC_OUTPUT:      rd_word = adc_word[5];
      dab_pkg::IDX_ADC_BYPASS:      rd_word = adc_bypass_q;
      dab_pkg::IDX_FORCED_FAULT:    rd_word = forced_fault_q;
      default: begin
        rd_hit  = 1'b0;
        rd_word = dab_pkg::ZERO_WORD;
      end
    endcase
  end

  // Read channel state; arready returns only once the answer has been taken.
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      rd_state_q <= dab_pkg::DAB_IDLE;
    end else begin
      case (rd_state_q)
        dab_pkg::DAB_IDLE: begin
          if (s_axi_arvalid && s_axi_arready) begin
            rd_state_q <= dab_pkg::DAB_RESP;
          end
        end
        dab_pkg::DAB_RESP: begin
          if (s_axi_rready) begin
            rd_state_q <= dab_pkg::DAB_IDLE;
          end
        end
        default: begin
          rd_state_q <= dab_pkg::DAB_IDLE;
        end
      endcase
    end
  end

  // One read at a time; arready drops while the answer waits for rready.
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= dab_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rdata   <= {16'h0000, rd_word};
      s_axi_rresp   <= rd_hit ? dab_pkg::RESP_OKAY : dab_pkg::RESP_SLVERR;
    end else if (rd_state_q == dab_pkg::DAB_RESP) begin
      if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end else begin
      s_axi_arready <= 1'b1;
    end
  end
endmodule

// >>> sim/dab_register_bank_properties.sv
// Checker for the converter register bank: bus answers, reset domains, reserved bits.
// Assumes it is bound to the register bank and sees only its ports.
`timescale 1ns/10ps
module dab_register_bank_checker (
  input wire logic        clock,
  input wire logic        rst_n,
  input wire logic        por_n,
  input wire logic        software_reset_command,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic        break_cmd_valid,
  input wire logic        break_cmd_write,
  input wire logic [5:0]  break_cmd_index,
  input wire logic [15:0] break_rdata_q,
  input wire logic [15:0] voltage_output_q,
  input wire logic [15:0] adc_bypass_q,
  input wire logic [15:0] forced_fault_q,
  input wire logic [15:0] special_config_q,
  input wire logic [31:0] s_axi_rdata
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_n);
  sequence s_ar_take;
    s_axi_arvalid && s_axi_arready;
  endsequence
  sequence s_r_answer;
    s_axi_rvalid && !s_axi_arready && s_axi_rdata[31:16] == 16'h0000;
  endsequence
  a_read_answer: assert property (s_ar_take |=> s_r_answer)
    else $error("read answer missing");
  a_ready_return: assert property (s_axi_rvalid && s_axi_rready |-> ##[1:3] s_axi_arready)
    else $error("read ready not back");
  a_soft_reset_clear: assert property (software_reset_command |=> voltage_output_q == 16'h0000
    && forced_fault_q == 16'h0000 && adc_bypass_q == 16'h0000)
    else $error("software reset left state");
  a_por_clear: assert property (!por_n |=> special_config_q == 16'h0000)
    else $error("power-on reset left config");
  a_special_kept: assert property (@(posedge clock) disable iff (!por_n)
    !rst_n || software_reset_command |=> $stable(special_config_q))
    else $error("config lost on reset");
  a_code_by_write: assert property ($changed(voltage_output_q) && $past(rst_n)
    && $past(por_n) && !$past(software_reset_command) |-> $rose(s_axi_bvalid))
    else $error("code changed without write");
  a_reserved_zero: assert property (adc_bypass_q[12] == 1'h0
    && forced_fault_q[11:10] == 2'h0 && special_config_q[15:5] == 11'h000)
    else $error("reserved bits set");
  a_break_rd_zero: assert property (break_cmd_valid && !break_cmd_write
    && break_cmd_index != 6'h16 |=> break_rdata_q == 16'h0000)
    else $error("break read leaked data");
endmodule

// >>> sim/dab_host_model.sv
// Host model: AXI4-Lite master issuing one register word per access.
// Assumes each task is entered in the time step of a rising clock edge.
`timescale 1ns/10ps
module dab_host_model (
  input  wire logic        clock,
  input  wire logic        s_axi_awready,
  input  wire logic        s_axi_wready,
  input  wire logic        s_axi_bvalid,
  input  wire logic        s_axi_arready,
  input  wire logic        s_axi_rvalid,
  input  wire logic [1:0]  s_axi_bresp,
  input  wire logic [1:0]  s_axi_rresp,
  input  wire logic [31:0] s_axi_rdata,
  output logic             s_axi_awvalid,
  output logic             s_axi_wvalid,
  output logic             s_axi_bready,
  output logic             s_axi_arvalid,
  output logic             s_axi_rready,
  output logic [7:0]       s_axi_awaddr,
  output logic [7:0]       s_axi_araddr,
  output logic [31:0]      s_axi_wdata,
  output logic [3:0]       s_axi_wstrb
);
  initial begin
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = '0;
  end
  // Released address and data lines are inverted so a stale value never passes for a fresh one.
  task automatic wr(input logic [5:0] i, input logic [15:0] d, input logic [3:0] s,
                    output logic [1:0] r);
    @(posedge clock);
    {s_axi_awaddr, s_axi_wdata, s_axi_wstrb} <= {i, 2'h0, 16'h0000, d, s};
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    do begin
      @(posedge clock);
      if (s_axi_awready) {s_axi_awvalid, s_axi_awaddr} <= {1'h0, ~s_axi_awaddr};
      if (s_axi_wready) {s_axi_wvalid, s_axi_wdata} <= {1'h0, ~s_axi_wdata};
    end while (!s_axi_bvalid);
    r = s_axi_bresp;
    s_axi_bready <= 1'h0;
  endtask
  task automatic rd(input logic [5:0] i, output logic [15:0] d, output logic [1:0] r);
    @(posedge clock);
    {s_axi_araddr, s_axi_arvalid, s_axi_rready} <= {i, 2'h0, 2'h3};
    do begin
      @(posedge clock);
      if (s_axi_arready) {s_axi_arvalid, s_axi_araddr} <= {1'h0, ~s_axi_araddr};
    end while (!s_axi_rvalid);
    {r, d} = {s_axi_rresp, s_axi_rdata[15:0]};
    s_axi_rready <= 1'h0;
  endtask
endmodule

// >>> sim/test_dac_adc_register_bank.sv
// Testbench of the converter register bank; the host model drives the bus.
// Assumes the core files and the sim models are compiled first.
`timescale 1ns/10ps
module test_dac_adc_register_bank;
  logic clock, rst_n, por_n, software_reset_command, break_cmd_valid, break_cmd_write;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, uart_break_mode_q;
  logic [1:0] s_axi_bresp, s_axi_rresp, rs;
  logic [3:0] s_axi_wstrb;
  logic [5:0] break_cmd_index;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [11:0] adc_input0_result, adc_input1_result, adc_temperature_result;
  logic [11:0] adc_selfdiag_result, adc_offset_result, adc_output_result;
  logic [15:0] break_cmd_wdata, break_rdata_q, general_status, adc_fault_flags, rd;
  logic [15:0] converter_output_readback, voltage_output_q, adc_bypass_q, forced_fault_q;
  logic [15:0] special_config_q;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  int n_fail = 0, cmp_count = 0, cyc = 0;
  dab_register_bank dut (.*);
  dab_host_model host (.*);
  initial begin
    clock = 1'h0;
    forever #2 clock = ~clock;
  end
  always @(posedge clock) if (++cyc == 5000) begin
    n_fail++;
    print_verdict();
  end
  task automatic chk(input string nm, input logic [17:0] e, input logic [17:0] g);
    cmp_count++;
    if (g !== e) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic rdc(input logic [5:0] i, input logic [15:0] e, input logic [1:0] er);
    host.rd(i, rd, rs);
    chk("read", {er, e}, {rs, rd});
  endtask
  task automatic wrc(input logic [5:0] i, input logic [15:0] d, input logic [1:0] er);
    host.wr(i, d, 4'h3, rs);
    chk("bresp", {16'h0000, er}, {16'h0000, rs});
  endtask
  task automatic brk(input logic w, input logic [5:0] i, input logic [15:0] d);
    {break_cmd_valid, break_cmd_write, break_cmd_index, break_cmd_wdata} <= {1'h1, w, i, d};
    @(posedge clock);
    break_cmd_valid <= 1'h0;
    repeat (2) @(posedge clock);
  endtask
  task automatic t_code;
    rdc(6'h01, 16'h0000, 2'h0);
    wrc(6'h01, 16'hA5C3, 2'h0);
    chk("voltage_output", 18'h0_A5C3, {2'h0, voltage_output_q});
    host.wr(6'h01, 16'hFFFF, 4'h1, rs);
    rdc(6'h01, 16'hA5FF, 2'h0);
    wrc(6'h00, 16'hFFFF, 2'h0);
    rdc(6'h00, 16'h0000, 2'h0);
    rdc(6'h01, 16'hA5FF, 2'h0);
    $display("code test done");
  endtask
  task automatic t_fields;
    {general_status, adc_fault_flags, converter_output_readback} <= {3{16'hFFFF}};
    {adc_input0_result, adc_output_result} <= {12'hABC, 12'h5A5};
    {adc_input1_result, adc_temperature_result} <= {12'h111, 12'h222};
    {adc_selfdiag_result, adc_offset_result} <= {12'h333, 12'h444};
    wrc(6'h2E, 16'hFFFF, 2'h0);
    rdc(6'h2E, 16'hEFFF, 2'h0);
    wrc(6'h2F, 16'hFFFF, 2'h0);
    rdc(6'h2F, 16'hF3FF, 2'h0);
    rdc(6'h21, 16'h91FF, 2'h0);
    rdc(6'h23, 16'h01FE, 2'h0);
    rdc(6'h24, 16'h0ABC, 2'h0);
    rdc(6'h25, 16'h0111, 2'h0);
    rdc(6'h26, 16'h0222, 2'h0);
    rdc(6'h27, 16'h0333, 2'h0);
    rdc(6'h28, 16'h0444, 2'h0);
    rdc(6'h2C, 16'hFFFF, 2'h0);
    rdc(6'h2D, 16'h05A5, 2'h0);
    wrc(6'h24, 16'h0123, 2'h2);
    rdc(6'h3A, 16'h0000, 2'h2);
    $display("field test done");
  endtask
  task automatic t_break;
    rdc(6'h16, 16'h0000, 2'h2);
    wrc(6'h16, 16'h0001, 2'h2);
    brk(1'h0, 6'h16, 16'h0000);
    chk("break data", 18'h0, {2'h0, break_rdata_q});
    brk(1'h1, 6'h16, 16'h0001);
    brk(1'h0, 6'h16, 16'h0000);
    chk("break mode", 18'h1, {17'h0_0000, uart_break_mode_q});
    chk("break data", 18'h1, {2'h0, break_rdata_q});
    rdc(6'h16, 16'h0000, 2'h2);
    wrc(6'h16, 16'h0000, 2'h2);
    chk("break mode", 18'h1, {17'h0_0000, uart_break_mode_q});
    brk(1'h0, 6'h01, 16'h0000);
    chk("break data", 18'h0, {2'h0, break_rdata_q});
    $display("break test done");
  endtask
  task automatic t_special;
    wrc(6'h0B, 16'hFFFF, 2'h0);
    rdc(6'h0B, 16'h001F, 2'h0);
    software_reset_command <= 1'h1;
    @(posedge clock);
    software_reset_command <= 1'h0;
    rst_n <= 1'h0;
    repeat (2) @(posedge clock);
    rst_n <= 1'h1;
    @(posedge clock);
    chk("special", 18'h0_001F, {2'h0, special_config_q});
    chk("fault", 18'h0, {2'h0, forced_fault_q});
    chk("voltage_output", 18'h0, {2'h0, voltage_output_q});
    por_n <= 1'h0;
    repeat (2) @(posedge clock);
    por_n <= 1'h1;
    @(posedge clock);
    chk("special", 18'h0, {2'h0, special_config_q});
    rdc(6'h01, 16'h0000, 2'h0);
    $display("reset test done");
  endtask
  task automatic print_verdict;
    $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  initial begin
    {rst_n, por_n, software_reset_command, break_cmd_valid, break_cmd_write} = 5'h00;
    {break_cmd_index, break_cmd_wdata, general_status, adc_fault_flags} = '0;
    {adc_input0_result, adc_input1_result, adc_temperature_result} = '0;
    {adc_selfdiag_result, adc_offset_result, adc_output_result} = '0;
    converter_output_readback = 16'h0000;
    repeat (20) @(posedge clock);
    {rst_n, por_n} <= 2'h3;
    t_code();
    t_fields();
    t_break();
    t_special();
    print_verdict();
  end
endmodule
bind dab_register_bank dab_register_bank_checker u_chk (.*);
